/* File: input_capture_port.sv */
// Purpose: input capture port, eight serial or seven serial plus parallel
// Assumes: register port with read data one cycle after the read strobe
// Notes: all pins pass two flip-flops before any logic reads them
//
// Function
// - eight serial, or seven serial plus parallel
// - threshold interrupt when count exceeds N
// - hang disable removes core stalls
// - bit 5 global DMA enable
// - write one clears overflow, reads zero
// - global enable gates FIFO entry
// - disable edge or flush bit empties FIFO
// - three-bit serial format per channel; the top bit of channel 7 is the flush bit and is held 0
// - single-channel modes take full 32 bits
// - parallel mask passes or blocks pins
// - bit 26 picks parallel pin source
// - two-bit parallel packing mode
// - bit 29 picks latch edge
// - packer reset strobe, self clearing
// - parallel enable takes channel 0
// - threshold interrupt serves core only
// - eight-deep FIFO, tagged serial words
// - status shows occupancy and overflows
module input_capture_port #(
	parameter int DEPTH = capture_pkg::FIFO_DEPTH
) (
	input wire logic clk_i,
	input wire logic sys_rst_i,
	input wire logic clk_en_i,
	input wire logic [4:0] addr_i,
	input wire logic [31:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	output logic [31:0] rdata_o,
	output logic stall_o, // core hang request
	input wire capture_pkg::ser_pins_type [7:0] ser_i,
	input wire capture_pkg::par_pins_type par_routed_i, // routing pins
	input wire capture_pkg::par_pins_type par_port_i, // parallel port
	input wire logic dma_req_i, // dma pops one word
	output logic dma_active_o,
	output logic [31:0] dma_data_o,
	output logic thresh_irq_o
);
	// ****************************************
	// registers
	// ****************************************
	logic [31:0] ctl_main_r, ctl_main_nxt; // only bits 5,4,3:0,7 stored
	logic [31:0] ctl_fmt_r, ctl_fmt_nxt;
	logic [31:0] ctl_par_r, ctl_par_nxt;
	logic [7:0] ovf_r, ovf_nxt;
	logic [31:0] rdata_r, rdata_nxt;
	logic stall_r, stall_nxt;
	logic irq_r, irq_nxt;
	logic en_q_r; // previous enable for falling-edge flush
	logic [31:0] mem [DEPTH];
	logic [3:0] cnt_r, cnt_nxt;
	logic [2:0] wp_r, wp_nxt, rp_r, rp_nxt;
	logic [31:0] dma_data_r, dma_data_nxt;
	logic dma_act_r;

	wire en = ctl_main_r[capture_pkg::EN_BIT];
	wire par_en = ctl_par_r[capture_pkg::PEN_BIT];

	// ****************************************
	// pin synchronisers and serial capture
	// ****************************************
	logic [7:0][2:0] s1_r, s2_r, s3_r; // s3 is delayed copy for edges
	logic [7:0] ser_vld; // one word per channel this cycle
	logic [7:0][31:0] ser_word;
	genvar g;
	generate
		for (g = 0; g < capture_pkg::NUM_CHAN; g++) begin : g_ser
			logic [31:0] sh_r, sh_nxt;
			logic [5:0] bc_r, bc_nxt;
			logic [2:0] fmt;
			logic [27:0] samp;
			logic rise, lrchg, lrtag, single;
			assign fmt = ctl_fmt_r[capture_pkg::FMT_LSB + 3*g +: 3];
			assign rise = s2_r[g][2] & ~s3_r[g][2];
			assign lrchg = s2_r[g][1] ^ s3_r[g][1];
			// single-channel word: 32 bits, no side tag
			assign single = (fmt == capture_pkg::FMT_LJ32) ||
				(fmt == capture_pkg::FMT_I2S32);
			// i2s marks left with low frame sync
			assign lrtag = (fmt == capture_pkg::FMT_I2S) ? ~s3_r[g][1] :
				s3_r[g][1];
			always_comb begin
				sh_nxt = sh_r;
				bc_nxt = bc_r;
				if (rise) begin
					sh_nxt = {sh_r[30:0], s2_r[g][0]};
					bc_nxt = (bc_r == 6'h3F) ? bc_r : bc_r + 6'h01;
				end
				if (lrchg)
					bc_nxt = 6'h00;
				// right-justified takes low bits, left-justified the top
				case (fmt)
					capture_pkg::FMT_RJ24: samp = {sh_r[23:0], 4'h0};
					capture_pkg::FMT_RJ20: samp = {sh_r[19:0], 8'h00};
					capture_pkg::FMT_RJ18: samp = {sh_r[17:0], 10'h000};
					capture_pkg::FMT_RJ16: samp = {sh_r[15:0], 12'h000};
					default: samp = sh_r[31:4];
				endcase
			end
			// word ends at a frame-sync change
			assign ser_vld[g] = lrchg && bc_r != 6'h00 &&
				!(g == 0 && par_en);
			assign ser_word[g] = single ? sh_r :
				{samp, lrtag, 3'(g)};
			always_ff @(posedge clk_i) begin
				if (sys_rst_i) begin
					sh_r <= 32'h0000_0000;
					bc_r <= 6'h00;
				end else if (clk_en_i) begin
					sh_r <= sh_nxt;
					bc_r <= bc_nxt;
				end
			end
		end
	endgenerate

	// ****************************************
	// parallel acquisition channel
	// ****************************************
	// both pin groups are synchronised before the select, so switching
	// the source never feeds a raw pin into logic
	capture_pkg::par_pins_type p1_r, p2_r; // routing pins, two-stage sync
	capture_pkg::par_pins_type q1_r, q2_r; // parallel-port pins, same
	capture_pkg::par_pins_type pp; // selected, synchronised pins
	logic pclk_q_r;
	logic [31:0] pk_r, pk_nxt;
	logic [1:0] pn_r, pn_nxt;
	logic par_vld;
	logic [19:0] pd;
	logic pedge;
	always_comb begin
		// pin source select
		pp = ctl_par_r[capture_pkg::PSEL_BIT] ? q2_r : p2_r;
		pd = pp.data & ctl_par_r[19:0];
		// rising when bit is 0, falling when 1
		pedge = ctl_par_r[capture_pkg::EDGE_BIT] ?
			(pclk_q_r & ~pp.clk) : (~pclk_q_r & pp.clk);
		pk_nxt = pk_r;
		pn_nxt = pn_r;
		par_vld = 1'b0;
		if (par_en && pedge) begin
			case (ctl_par_r[capture_pkg::PACK_LSB +: 2])
				capture_pkg::PACK_8: begin
					pk_nxt = {pk_r[23:0], pd[19:12]};
					pn_nxt = pn_r + 2'h1;
					par_vld = (pn_r == 2'h3);
				end
				capture_pkg::PACK_11: begin
					pk_nxt = (pn_r == 2'h2) ? {pk_r[21:0], pd[19:10]} :
						{pk_r[20:0], pd[19:9]};
					pn_nxt = (pn_r == 2'h2) ? 2'h0 : pn_r + 2'h1;
					par_vld = (pn_r == 2'h2);
				end
				capture_pkg::PACK_16: begin
					pk_nxt = {pk_r[15:0], pd[19:4]};
					pn_nxt = {1'b0, ~pn_r[0]};
					par_vld = pn_r[0];
				end
				default: begin
					pk_nxt = {pd, 12'h000};
					pn_nxt = 2'h0;
					par_vld = 1'b1;
				end
			endcase
		end
		// strobe drops any half-packed word
		if (wr_i && addr_i == 5'(capture_pkg::OFS_CTL_PAR) &&
			wdata_i[capture_pkg::PRST_BIT]) begin
			pn_nxt = 2'h0;
			par_vld = 1'b0;
		end
	end

	// ****************************************
	// fifo and register port
	// ****************************************
	logic [7:0] req;
	logic push, pop, core_rd, flush, full, empty;
	logic [31:0] in_word;
	always_comb begin
		req = ser_vld;
		if (par_vld)
			req[0] = 1'b1; // parallel owns slot 0
		in_word = 32'h0000_0000;
		// lowest channel wins, the others are lost; same-cycle rivals are rare at audio rates
		for (int i = capture_pkg::NUM_CHAN - 1; i >= 0; i--)
			if (req[i])
				in_word = (i == 0 && par_vld) ? pk_nxt : ser_word[i];
		full = (cnt_r == 4'(DEPTH));
		empty = (cnt_r == 4'h0);
		core_rd = rd_i && addr_i == capture_pkg::OFS_FIFO;
		// dma only while the dma enable bit is set
		pop = !empty && (core_rd ||
			(dma_req_i && ctl_main_r[capture_pkg::DMA_BIT]));
		push = en && |req && (!full || pop);
		flush = (en_q_r && !en) || (wr_i &&
			addr_i == 5'(capture_pkg::OFS_CTL_FMT) &&
			wdata_i[capture_pkg::FLUSH_BIT]);
		wp_nxt = wp_r;
		rp_nxt = rp_r;
		cnt_nxt = cnt_r;
		if (push)
			wp_nxt = 3'(wp_r + 3'h1);
		if (pop)
			rp_nxt = 3'(rp_r + 3'h1);
		cnt_nxt = 4'(cnt_r + {3'h0, push} - {3'h0, pop});
		if (flush) begin
			wp_nxt = 3'h0;
			rp_nxt = 3'h0;
			cnt_nxt = 4'h0;
		end
		// overflow: set wins over clear
		ovf_nxt = ovf_r;
		if (wr_i && addr_i == 5'(capture_pkg::OFS_CTL_MAIN) &&
			wdata_i[capture_pkg::CLROVR_BIT])
			ovf_nxt = 8'h00;
		if (en && full && !pop)
			ovf_nxt = ovf_nxt | req;
		// hang on empty read unless disabled
		stall_nxt = core_rd && empty && !ctl_main_r[capture_pkg::BHD_BIT];
		// threshold above N, only up to 7
		irq_nxt = ctl_main_r[3:0] <= 4'(capture_pkg::THRESH_MAX) &&
			cnt_nxt > ctl_main_r[3:0];
		ctl_main_nxt = ctl_main_r;
		ctl_fmt_nxt = ctl_fmt_r;
		ctl_par_nxt = ctl_par_r;
		if (wr_i) begin
			case (addr_i)
				5'(capture_pkg::OFS_CTL_MAIN): ctl_main_nxt = {24'h00_0000,
					wdata_i[7], 1'b0, wdata_i[5:0]};
				5'(capture_pkg::OFS_CTL_FMT): ctl_fmt_nxt = {1'b0,
					wdata_i[30:0]};
				5'(capture_pkg::OFS_CTL_PAR): ctl_par_nxt = {wdata_i[31],
					1'b0, wdata_i[29:26], 6'h00, wdata_i[19:0]};
				default: ;
			endcase
		end
		rdata_nxt = 32'h0000_0000;
		if (rd_i) begin
			case (addr_i)
				5'(capture_pkg::OFS_CTL_MAIN): rdata_nxt = ctl_main_r;
				5'(capture_pkg::OFS_CTL_FMT): rdata_nxt = ctl_fmt_r;
				5'(capture_pkg::OFS_CTL_PAR): rdata_nxt = ctl_par_r;
				5'(capture_pkg::OFS_STATUS): rdata_nxt = {cnt_r, 12'h000,
					ovf_r, 8'h00};
				capture_pkg::OFS_FIFO: rdata_nxt = empty ? 32'h0000_0000 :
					mem[rp_r];
				default: rdata_nxt = 32'h0000_0000;
			endcase
		end
		dma_data_nxt = (pop && !core_rd) ? mem[rp_r] : dma_data_r;
	end

	// ****************************************
	// state registers
	// ****************************************
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			s1_r <= '0;
			s2_r <= '0;
			s3_r <= '0;
			p1_r <= '0;
			p2_r <= '0;
			q1_r <= '0;
			q2_r <= '0;
			pclk_q_r <= 1'b0;
			pk_r <= 32'h0000_0000;
			pn_r <= 2'h0;
			ctl_main_r <= capture_pkg::CTL_RST;
			ctl_fmt_r <= capture_pkg::CTL_RST;
			ctl_par_r <= capture_pkg::CTL_RST;
			ovf_r <= 8'h00;
			rdata_r <= 32'h0000_0000;
			stall_r <= 1'b0;
			irq_r <= 1'b0;
			en_q_r <= 1'b0;
			cnt_r <= 4'h0;
			wp_r <= 3'h0;
			rp_r <= 3'h0;
			dma_data_r <= 32'h0000_0000;
			dma_act_r <= 1'b0;
		end else if (clk_en_i) begin
			s1_r <= ser_i;
			s2_r <= s1_r;
			s3_r <= s2_r;
			p1_r <= par_routed_i;
			p2_r <= p1_r;
			q1_r <= par_port_i;
			q2_r <= q1_r;
			pclk_q_r <= pp.clk;
			pk_r <= pk_nxt;
			pn_r <= pn_nxt;
			ctl_main_r <= ctl_main_nxt;
			ctl_fmt_r <= ctl_fmt_nxt;
			ctl_par_r <= ctl_par_nxt;
			ovf_r <= ovf_nxt;
			rdata_r <= rdata_nxt;
			stall_r <= stall_nxt;
			irq_r <= irq_nxt;
			en_q_r <= en;
			cnt_r <= cnt_nxt;
			wp_r <= wp_nxt;
			rp_r <= rp_nxt;
			dma_data_r <= dma_data_nxt;
			dma_act_r <= ctl_main_r[capture_pkg::DMA_BIT] & en;
			if (push && !flush)
				mem[wp_r] <= in_word;
		end
	end

	assign rdata_o = rdata_r;
	assign stall_o = stall_r;
	assign thresh_irq_o = irq_r;
	assign dma_active_o = dma_act_r;
	assign dma_data_o = dma_data_r;
endmodule

/* File: capture_pkg.sv */
// Purpose: shared constants and types for the input capture port
// Assumes: 32-bit register port, 20 MHz system clock
// Notes: offsets of the register map are chosen locally
package capture_pkg;
	// ****************************************
	// register offsets
	// ****************************************
	localparam logic [3:0] OFS_CTL_MAIN = 4'h0; // port_control_main
	localparam logic [3:0] OFS_CTL_FMT = 4'h4; // channel_format_control
	localparam logic [3:0] OFS_CTL_PAR = 4'h8; // parallel_acquire_control
	localparam logic [3:0] OFS_STATUS = 4'hC; // port_status
	// capture_fifo_output sits beyond the four-bit map, in its own decode
	localparam logic [4:0] OFS_FIFO = 5'h10;
	// ****************************************
	// field positions
	// ****************************************
	localparam int NSET_LSB = 0; // fifo_threshold_count 3:0
	localparam int BHD_BIT = 4; // hang_disable
	localparam int DMA_BIT = 5; // port_dma_enable
	localparam int CLROVR_BIT = 6; // overflow_clear
	localparam int EN_BIT = 7; // port_global_enable
	localparam int FMT_LSB = 8; // channel0_format_select 10:8
	localparam int FLUSH_BIT = 31; // flush in channel_format_control
	localparam int PSEL_BIT = 26; // parallel_pin_source_select
	localparam int PACK_LSB = 27; // parallel_packing_mode 28:27
	localparam int EDGE_BIT = 29; // parallel_latch_edge
	localparam int PRST_BIT = 30; // parallel_packer_reset
	localparam int PEN_BIT = 31; // parallel_channel_enable
	localparam int OVF_LSB = 8; // sticky overflows 15:8
	localparam int SZ_LSB = 28; // fifo_occupancy 31:28
	// ****************************************
	// reset values and counts
	// ****************************************
	localparam logic [31:0] CTL_RST = 32'h0000_0000;
	localparam int FIFO_DEPTH = 8;
	localparam int THRESH_MAX = 7;
	localparam int PAR_WIDTH = 20;
	localparam int NUM_CHAN = 8;
	localparam int SER_BITS = 32; // bits per slot in a serial frame
	// serial formats
	localparam logic [2:0] FMT_LJ = 3'h0;
	localparam logic [2:0] FMT_I2S = 3'h1;
	localparam logic [2:0] FMT_LJ32 = 3'h2;
	localparam logic [2:0] FMT_I2S32 = 3'h3;
	localparam logic [2:0] FMT_RJ24 = 3'h4;
	localparam logic [2:0] FMT_RJ20 = 3'h5;
	localparam logic [2:0] FMT_RJ18 = 3'h6;
	localparam logic [2:0] FMT_RJ16 = 3'h7;
	// packing modes
	localparam logic [1:0] PACK_8 = 2'h0;
	localparam logic [1:0] PACK_11 = 2'h1;
	localparam logic [1:0] PACK_16 = 2'h2;
	localparam logic [1:0] PACK_20 = 2'h3;
	// serial pins of one channel
	typedef struct packed {
		logic sclk;
		logic lrclk;
		logic sdata;
	} ser_pins_type;
	// parallel pins (data plus clock)
	typedef struct packed {
		logic clk;
		logic [19:0] data;
	} par_pins_type;
endpackage

/* File: source_model.sv */
// Purpose: far-side serial audio and parallel sources
// Assumes: the bench may start and stop traffic in the middle of a word
// Notes: idle clocks stay low, idle data toggles every half period while bit 2 of nbit is clear and holds while it is set
module source_model (
	input wire logic [7:0] ser_mask_i, // channels that send frames
	input wire logic par_run_i, // parallel clock runs
	input wire logic [19:0] par_data_i, // sample on the top pins
	output capture_pkg::ser_pins_type [7:0] ser_o,
	output capture_pkg::par_pins_type par_o
);
	timeunit 1ns;
	timeprecision 1ns;
	logic sclk = 1'b0, lr = 1'b0, sd = 1'b0, pclk = 1'b0;
	int nbit = 0; // bits sent, a word ends on each lrclk change
	// ****
	// 400 ns link clock, frozen outside frames
	// ****
	always begin
		#200;
		pclk = par_run_i ? ~pclk : 1'b0;
		sclk = (|ser_mask_i) ? ~sclk : 1'b0;
		if (!sclk) begin
			sd = ~sd ^ nbit[2]; // idle data moves too while bit 2 of nbit is clear, and holds while it is set
			nbit = nbit + ((|ser_mask_i) ? 1 : 0);
			if ((|ser_mask_i) && nbit % 32 == 0)
				lr = ~lr;
		end
	end
	// unselected channels show a dead clock and moving data
	always_comb begin
		for (int i = 0; i < 8; i++)
			ser_o[i] = ser_mask_i[i] ? {sclk, lr, sd} : {2'h0, ~sd};
	end
	assign par_o = {pclk, par_data_i};
endmodule

/* File: capture_props.sv */
// Purpose: port-level checks of the input capture port
// Assumes: clk_en_i stays high
// Notes: a shadow of port_control_main follows register writes
module capture_props #(
	parameter int DEPTH = 8
) (
	input wire logic clk_i,
	input wire logic sys_rst_i,
	input wire logic [4:0] addr_i,
	input wire logic [31:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	input wire logic [31:0] rdata_o,
	input wire logic stall_o,
	input wire logic dma_active_o,
	input wire logic thresh_irq_o
);
	logic [7:0] ctl_r, ctl_nxt; // shadow of the low control byte
	always_comb begin
		ctl_nxt = (wr_i && addr_i == 5'h00) ? wdata_i[7:0] : ctl_r;
	end
	always_ff @(posedge clk_i) begin
		ctl_r <= sys_rst_i ? 8'h00 : ctl_nxt;
	end
	default clocking @(posedge clk_i); endclocking
	default disable iff (sys_rst_i);
	// ****
	// properties
	// ****
	property p_stall; stall_o |-> $past(rd_i) && $past(addr_i) == 5'h10
		&& !$past(ctl_r[4]) && rdata_o == 32'h0000_0000; endproperty
	a_stall: assert property (p_stall) else $error("bad stall");
	property p_ctl_rb; $past(rd_i) && $past(addr_i) == 5'h00
		|-> rdata_o[7:0] == ($past(ctl_r) & 8'hbf); endproperty
	a_ctl_rb: assert property (p_ctl_rb) else $error("ctl read");
	property p_flush_rb; $past(rd_i) && $past(addr_i) == 5'h04
		|-> !rdata_o[31]; endproperty
	a_flush_rb: assert property (p_flush_rb) else $error("flush");
	property p_prst_rb; $past(rd_i) && $past(addr_i) == 5'h08
		|-> !rdata_o[30]; endproperty
	a_prst_rb: assert property (p_prst_rb) else $error("prst");
	property p_size; $past(rd_i) && $past(addr_i) == 5'h0c
		|-> rdata_o[31:28] <= DEPTH; endproperty
	a_size: assert property (p_size) else $error("size");
	// the level was computed from the threshold of the cycle before
	property p_irq_n; $rose(thresh_irq_o) |-> $past(ctl_r[3:0]) <= 4'h7;
	endproperty
	a_irq_n: assert property (p_irq_n) else $error("irq n");
	property p_dma_on; (ctl_r[7] && ctl_r[5]) [*3] |-> dma_active_o;
	endproperty
	a_dma_on: assert property (p_dma_on) else $error("dma on");
	property p_dma_off; (!ctl_r[5]) [*3] |-> !dma_active_o; endproperty
	a_dma_off: assert property (p_dma_off) else $error("dma off");
	property p_quiet; (!ctl_r[7]) [*4] |-> !thresh_irq_o; endproperty
	a_quiet: assert property (p_quiet) else $error("irq off");
	c_stall: cover property (stall_o);
	c_irq: cover property ($rose(thresh_irq_o));
	c_dma: cover property (dma_active_o);
endmodule
bind input_capture_port capture_props #(.DEPTH(DEPTH)) i_props (
	.clk_i(clk_i), .sys_rst_i(sys_rst_i), .addr_i(addr_i),
	.wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
	.stall_o(stall_o), .dma_active_o(dma_active_o),
	.thresh_irq_o(thresh_irq_o));

/* File: testbench.sv */
// Purpose: self-checking bench of the input capture port
// Assumes: source_model supplies serial and parallel traffic
// Notes: occupancy and packed words are modelled here
module testbench;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk_i = 1'b0, sys_rst_i = 1'b1, wr_i = 1'b0, rd_i = 1'b0;
	logic dma_req_i = 1'b0, par_run = 1'b0, psel = 1'b0, stl;
	logic lr_prev; // side tag of the word popped before
	logic stall_o, dma_active_o, thresh_irq_o;
	logic [4:0] addr_i = 5'h00;
	logic [31:0] wdata_i = 32'h0000_0000, rdata_o, dma_data_o, got;
	logic [7:0] ser_mask = 8'h00;
	logic [19:0] pdat = 20'h0_0000, pm;
	capture_pkg::ser_pins_type [7:0] ser;
	capture_pkg::par_pins_type par, alt;
	int n_fail = 0, samples_checked = 0, seed = 91, occ;
	`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin \
		n_fail++; $display("wrong value %0t %h", $time, a); end end
	always #25 clk_i = ~clk_i;
	source_model i_src (.ser_mask_i(ser_mask), .par_run_i(par_run),
		.par_data_i(pdat), .ser_o(ser), .par_o(par));
	assign alt = {par.clk, ~par.data}; // wrong pins carry other data
	input_capture_port i_dut (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
		.clk_en_i(1'b1), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
		.rd_i(rd_i), .rdata_o(rdata_o), .stall_o(stall_o), .ser_i(ser),
		.par_routed_i(psel ? alt : par), .par_port_i(psel ? par : alt),
		.dma_req_i(dma_req_i), .dma_active_o(dma_active_o),
		.dma_data_o(dma_data_o), .thresh_irq_o(thresh_irq_o));
	// ****
	// bus tasks and model
	// ****
	task automatic end_sim;
		$display("checks %0d fails %0d", samples_checked, n_fail);
		if (n_fail == 0 && samples_checked > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	task automatic wr(input logic [4:0] a, input logic [31:0] d);
		@(posedge clk_i);
		addr_i <= a;
		wdata_i <= d;
		wr_i <= 1'b1;
		@(posedge clk_i);
		wr_i <= 1'b0;
	endtask
	// data and stall stand only in the cycle after the strobe
	task automatic rd(input logic [4:0] a);
		@(posedge clk_i);
		addr_i <= a;
		rd_i <= 1'b1;
		@(posedge clk_i);
		rd_i <= 1'b0;
		#1 got = rdata_o;
		stl = stall_o;
	endtask
	task automatic dma_pop;
		@(posedge clk_i);
		dma_req_i <= 1'b1;
		@(posedge clk_i);
		dma_req_i <= 1'b0;
		#1 got = dma_data_o;
	endtask
	// polling is bounded, a hang ends the run as a failure
	task automatic wait_occ(input logic [3:0] n);
		for (int k = 0; k < 2000; k++) begin
			rd(5'h0c);
			if (got[31:28] >= n)
				return;
		end
		n_fail++;
		end_sim();
	endtask
	function automatic logic [31:0] pack(input int m, input logic [19:0] d);
		case (m)
			0: return {4{d[19:12]}};
			1: return {d[19:9], d[19:9], d[19:10]};
			2: return {2{d[19:4]}};
			default: return {d, 12'h000};
		endcase
	endfunction
	// ****
	// main sequence
	// ****
	initial begin
		repeat (16) @(posedge clk_i);
		sys_rst_i <= 1'b0;
		for (int a = 0; a < 24; a += 4) begin
			rd(a[4:0]);
			`CHK(got, 32'h0000_0000)
		end
		`CHK(stl, 1'b0)
		rd(5'h10);
		`CHK(stl, 1'b1)
		wr(5'h00, 32'h0000_0010);
		rd(5'h10);
		`CHK(stl, 1'b0)
		for (int f = 0; f < 8; f++) begin
			wr(5'h04, f << 8);
			rd(5'h04);
			`CHK(got[10:8], f[2:0])
		end
		ser_mask <= 8'h02;
		repeat (600) @(posedge clk_i);
		rd(5'h0c);
		`CHK(got[31:28], 4'h0)
		wr(5'h00, 32'h0000_0082);
		wait_occ(8);
		repeat (700) @(posedge clk_i);
		ser_mask <= 8'h00;
		dma_pop(); // dma is off, nothing leaves
		rd(5'h0c);
		`CHK(got[31:28], 4'h8)
		`CHK(got[15:8], 8'h02)
		`CHK(thresh_irq_o, 1'b1)
		wr(5'h00, 32'h0000_00c2);
		rd(5'h0c);
		`CHK(got[15:8], 8'h00)
		for (occ = 8; occ > 0; occ--) begin
			rd(5'h0c);
			`CHK(got[31:28], occ[3:0])
			`CHK(thresh_irq_o, occ > 2)
			rd(5'h10);
			`CHK(got[2:0], 3'h1)
			// consecutive words of one channel alternate sides
			if (occ < 8)
				`CHK(got[3], ~lr_prev)
			lr_prev = got[3];
		end
		wr(5'h00, 32'h0000_0088);
		ser_mask <= 8'h02;
		wait_occ(8);
		ser_mask <= 8'h00;
		// a cut frame may still end a word; let it meet the full fifo
		repeat (8) @(posedge clk_i);
		`CHK(thresh_irq_o, 1'b0)
		wr(5'h04, 32'h8000_0000);
		rd(5'h0c);
		`CHK(got[31:28], 4'h0)
		ser_mask <= 8'h02;
		wait_occ(2);
		ser_mask <= 8'h00;
		wr(5'h00, 32'h0000_0008);
		rd(5'h0c);
		`CHK(got[31:28], 4'h0)
		wr(5'h00, 32'h0000_00a8);
		rd(5'h0c);
		`CHK(dma_active_o, 1'b1)
		for (int m = 0; m < 4; m++) begin
			pdat <= 20'($random(seed));
			pm <= 20'($random(seed));
			psel <= m[0];
			wr(5'h04, 32'h8000_0000);
			wr(5'h08, {2'h3, m[1], m[1:0], m[0], 6'h00, pm});
			par_run <= 1'b1;
			wait_occ(1);
			par_run <= 1'b0;
			// the last clock edge must land before the next flush
			repeat (12) @(posedge clk_i);
			dma_pop();
			`CHK(got, pack(m, pdat & pm))
		end
		end_sim();
	end
endmodule
